//--- hw/self_test_control.sv
// self-test control block: test control and ADC override registers on AXI4-Lite,
// calibration-check sequencing, fault injection, forced trips and override datapath
// assumes an external calibration engine (start/abort/done/fail) and that a trip
// output leads to a device reset which drives nrst_in low
`timescale 1ns/10ps
module self_test_control
  import self_test_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // register bus
  input wire axil_req_t axil_in,
  output axil_rsp_t axil_out,
  // calibration engine
  output logic cal_start_out,
  output logic cal_full_out,
  output logic cal_abort_out,
  output logic cal_busy_out,
  input wire logic cal_done_in,
  input wire logic cal_fail_in,
  // fault injection and forced trips
  output logic [ECC_W-1:0] error_check_result_out,
  output logic digital_die_overtemp_force_out,
  output logic analog_die_overtemp_force_out,
  output logic pass_transistor_check_force_out,
  // adc datapath
  input wire adc_sample_t adc_sample_in,
  input wire logic [ADC_W-1:0] trim_offset_in,
  output adc_sample_t adc_result_out,
  // interrupt
  output logic irq_out
);

  state_t s_q;
  state_t s_d;

  logic aw_take;
  logic w_take;
  logic wr_fire;
  logic ar_take;
  logic [9:0] widx;
  logic [9:0] ridx;
  logic [31:0] merged;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;
  logic [ADC_W-1:0] conv_val;
  logic full_req;
  logic part_req;

  function automatic logic [9:0] reg_index(input logic [ADDR_W-1:0] addr);
    reg_index = addr[ADDR_W-1:2];
  endfunction : reg_index

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    merge_bytes = r;
  endfunction : merge_bytes

  // saturate instead of wrapping so a trimmed full-scale code stays full scale
  function automatic logic [ADC_W-1:0] trim_sat(input logic [ADC_W-1:0] a,
                                               input logic [ADC_W-1:0] b);
    logic [ADC_W:0] sum;
    sum = {a[ADC_W-1], a} + {b[ADC_W-1], b};
    if (sum[ADC_W] != sum[ADC_W-1]) begin
      trim_sat = sum[ADC_W] ? ADC_MIN : ADC_MAX;
    end else begin
      trim_sat = sum[ADC_W-1:0];
    end
  endfunction : trim_sat

  function automatic logic [31:0] ctrl_word(input state_t s);
    logic [31:0] r;
    r = 32'h0000_0000;
    r[CTRL_ECC_LSB +: 3] = s.ecc_sel;
    r[CTRL_FULL_BIT] = (s.cal_state == CAL_FULL);
    r[CTRL_PART_BIT] = (s.cal_state == CAL_PARTIAL);
    r[CTRL_DIG_BIT] = s.trips[2];
    r[CTRL_ANA_BIT] = s.trips[1];
    r[CTRL_PASS_BIT] = s.trips[0];
    ctrl_word = r;
  endfunction : ctrl_word

  assign aw_take = axil_in.awvalid && !s_q.aw_have && !s_q.bvalid;
  assign w_take = axil_in.wvalid && !s_q.w_have && !s_q.bvalid;
  assign wr_fire = s_q.aw_have && s_q.w_have && !s_q.bvalid;
  assign ar_take = axil_in.arvalid && !s_q.rvalid;
  assign widx = reg_index(s_q.aw_addr);
  assign ridx = reg_index(axil_in.araddr);
  assign full_req = wr_fire && (widx == IDX_CTRL) && s_q.w_strb[0] &&
                    s_q.w_data[CTRL_FULL_BIT];
  assign part_req = wr_fire && (widx == IDX_CTRL) && s_q.w_strb[0] &&
                    s_q.w_data[CTRL_PART_BIT];
  // conversion still runs; only its result is replaced
  assign conv_val = s_q.ovr_en ? s_q.ovr_val : adc_sample_in.data;

  always_comb begin
    s_d = s_q;
    s_d.cal_start = 1'b0;
    s_d.cal_abort = 1'b0;
    merged = 32'h0000_0000;
    ev = '0;
    clr = '0;

    if (aw_take) begin
      s_d.aw_have = 1'b1;
      s_d.aw_addr = axil_in.awaddr;
    end
    if (w_take) begin
      s_d.w_have = 1'b1;
      s_d.w_data = axil_in.wdata;
      s_d.w_strb = axil_in.wstrb;
    end

    // engine completion is handled first so a same-cycle start still wins, except a partial request while a full check completes
    if (cal_done_in) begin
      case (s_q.cal_state)
        CAL_FULL: begin
          s_d.cal_state = CAL_IDLE;
          s_d.cal_err = cal_fail_in;
          ev[IRQ_FULL_DONE] = 1'b1;
          ev[IRQ_CAL_FAIL] = cal_fail_in;
        end
        CAL_PARTIAL: begin
          s_d.cal_state = CAL_IDLE;
          ev[IRQ_PART_DONE] = 1'b1;
          ev[IRQ_CAL_FAIL] = cal_fail_in;
        end
        default: begin
        end
      endcase
    end

    if (wr_fire) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      case (widx)
        IDX_CTRL: begin
          merged = merge_bytes(ctrl_word(s_q), s_q.w_data, s_q.w_strb);
          s_d.trips[2] = merged[CTRL_DIG_BIT];
          s_d.trips[1] = merged[CTRL_ANA_BIT];
          s_d.trips[0] = merged[CTRL_PASS_BIT];
          if (s_q.w_strb[0]) begin
            s_d.ecc_sel = merged[CTRL_ECC_LSB +: 3];
            case (merged[CTRL_ECC_LSB +: 3])
              ECC_USER_CORR: s_d.ecc_result[0] = 1'b1;
              ECC_USER_UNCORR: s_d.ecc_result[1] = 1'b1;
              ECC_VEND_CORR: s_d.ecc_result[2] = 1'b1;
              ECC_VEND_UNCORR: s_d.ecc_result[3] = 1'b1;
              default: begin
                // code 0 and reserved codes set no result bit
                s_d.ecc_result = s_q.ecc_result;
              end
            endcase
          end
          if (full_req) begin
            s_d.cal_state = CAL_FULL;
            s_d.cal_start = 1'b1;
            s_d.cal_abort = (s_q.cal_state == CAL_PARTIAL);
            s_d.cal_err = 1'b0;
          end else if (part_req) begin
            if (s_q.cal_state == CAL_FULL) begin
              ev[IRQ_PART_IGNORED] = 1'b1;
            end else if (s_q.cal_state == CAL_IDLE || cal_done_in) begin
              s_d.cal_state = CAL_PARTIAL;
              s_d.cal_start = 1'b1;
            end
          end
        end
        IDX_OVR: begin
          merged = merge_bytes({8'h00, s_q.ovr_en, 9'h000, s_q.ovr_val}, s_q.w_data,
                               s_q.w_strb);
          s_d.ovr_en = merged[OVR_EN_BIT];
          s_d.ovr_val = merged[ADC_W-1:0];
        end
        IDX_IRQ_CLR: begin
          merged = merge_bytes(32'h0000_0000, s_q.w_data, s_q.w_strb);
          clr = merged[IRQ_W-1:0];
        end
        IDX_IRQ_EN: begin
          merged = merge_bytes({28'h0000000, s_q.irq_enable}, s_q.w_data, s_q.w_strb);
          s_d.irq_enable = merged[IRQ_W-1:0];
        end
        IDX_IRQ_STAT, IDX_ECC_RSLT, IDX_FAULT: begin
          // read-only: write accepted and dropped
        end
        default: begin
          s_d.bresp = RESP_SLVERR;
        end
      endcase
    end else if (s_q.bvalid && axil_in.bready) begin
      s_d.bvalid = 1'b0;
    end

    if (ar_take) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = RESP_OKAY;
      s_d.rdata = 32'h0000_0000;
      case (ridx)
        IDX_CTRL: s_d.rdata = ctrl_word(s_q);
        IDX_OVR: s_d.rdata = {8'h00, s_q.ovr_en, 9'h000, s_q.ovr_val};
        IDX_IRQ_STAT: s_d.rdata[IRQ_W-1:0] = s_q.irq_status;
        IDX_IRQ_CLR: s_d.rdata = 32'h0000_0000;
        IDX_IRQ_EN: s_d.rdata[IRQ_W-1:0] = s_q.irq_enable;
        IDX_ECC_RSLT: s_d.rdata[ECC_W-1:0] = s_q.ecc_result;
        IDX_FAULT: s_d.rdata[FAULT_CAL_ERR_BIT] = s_q.cal_err;
        default: s_d.rresp = RESP_SLVERR;
      endcase
    end else if (s_q.rvalid && axil_in.rready) begin
      s_d.rvalid = 1'b0;
    end

    // set beats clear so an event in the clearing cycle survives
    s_d.irq_status = (s_q.irq_status & ~clr) | ev;

    s_d.result.valid = adc_sample_in.valid;
    if (adc_sample_in.valid) begin
      s_d.result.chan = adc_sample_in.chan;
      s_d.result.data = trim_sat(conv_val, trim_offset_in);
    end
  end

  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign axil_out.awready = !s_q.aw_have && !s_q.bvalid;
  assign axil_out.wready = !s_q.w_have && !s_q.bvalid;
  assign axil_out.bvalid = s_q.bvalid;
  assign axil_out.bresp = s_q.bresp;
  assign axil_out.arready = !s_q.rvalid;
  assign axil_out.rvalid = s_q.rvalid;
  assign axil_out.rdata = s_q.rdata;
  assign axil_out.rresp = s_q.rresp;

  assign cal_start_out = s_q.cal_start;
  assign cal_abort_out = s_q.cal_abort;
  // partial check runs in compare-only mode, factory results stay intact
  assign cal_full_out = (s_q.cal_state == CAL_FULL);
  assign cal_busy_out = (s_q.cal_state != CAL_IDLE);
  assign error_check_result_out = s_q.ecc_result;
  // trips stay asserted until a control write clears their bit or the resulting reset clears them
  assign digital_die_overtemp_force_out = s_q.trips[2];
  assign analog_die_overtemp_force_out = s_q.trips[1];
  assign pass_transistor_check_force_out = s_q.trips[0];
  assign adc_result_out = s_q.result;
  assign irq_out = |(s_q.irq_status & s_q.irq_enable);

  property p_ctrl_rsvd_zero;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    ar_take && (ridx == IDX_CTRL) |=> axil_out.rvalid && (axil_out.rdata[15:8] == 8'h00);
  endproperty
  a_ctrl_rsvd_zero: assert property (p_ctrl_rsvd_zero)
    else $error("control reserved bits not zero");

  property p_ecc_load;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    wr_fire && (widx == IDX_CTRL) && s_q.w_strb[0] &&
    (s_q.w_data[CTRL_ECC_LSB +: 3] == ECC_USER_UNCORR) |=> error_check_result_out[1];
  endproperty
  a_ecc_load: assert property (p_ecc_load)
    else $error("selector code 2 did not load result");

  property p_ecc_hold;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    wr_fire && (widx == IDX_CTRL) && s_q.w_strb[0] &&
    ((s_q.w_data[CTRL_ECC_LSB +: 3] == ECC_NONE) ||
     (s_q.w_data[CTRL_ECC_LSB +: 3] > ECC_VEND_UNCORR)) |=>
    $stable(error_check_result_out);
  endproperty
  a_ecc_hold: assert property (p_ecc_hold)
    else $error("null or reserved selector changed result");

  property p_full_start;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    full_req |=> (cal_start_out && cal_full_out) ##1 (cal_full_out || $past(cal_done_in));
  endproperty
  a_full_start: assert property (p_full_start)
    else $error("full check not running after start");

  property p_full_fail;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    cal_full_out && cal_done_in && cal_fail_in && !full_req |=> !cal_full_out && s_q.cal_err;
  endproperty
  a_full_fail: assert property (p_full_fail)
    else $error("failed full check not flagged");

  property p_abort_partial;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    full_req && (s_q.cal_state == CAL_PARTIAL) |=>
    cal_abort_out && cal_full_out && (s_q.cal_state != CAL_PARTIAL);
  endproperty
  a_abort_partial: assert property (p_abort_partial)
    else $error("partial check not aborted by full start");

  property p_partial_done;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    (s_q.cal_state == CAL_PARTIAL) && cal_done_in && !wr_fire |=> !cal_busy_out;
  endproperty
  a_partial_done: assert property (p_partial_done)
    else $error("partial bit did not clear on completion");

  property p_partial_ignored;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    part_req && !full_req && cal_full_out && !cal_done_in |=>
    cal_full_out && !cal_start_out && s_q.irq_status[IRQ_PART_IGNORED];
  endproperty
  a_partial_ignored: assert property (p_partial_ignored)
    else $error("partial request disturbed full check");

  property p_trip_force;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    wr_fire && (widx == IDX_CTRL) && s_q.w_strb[0] && s_q.w_data[CTRL_DIG_BIT] |=>
    digital_die_overtemp_force_out;
  endproperty
  a_trip_force: assert property (p_trip_force)
    else $error("digital die trip not forced");

  property p_override;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    adc_sample_in.valid && s_q.ovr_en && (trim_offset_in == 14'h0000) |=>
    adc_result_out.valid && (adc_result_out.data == $past(s_q.ovr_val));
  endproperty
  a_override: assert property (p_override)
    else $error("override value not substituted");

  property p_trim;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    adc_sample_in.valid |=>
    adc_result_out.data == trim_sat($past(conv_val), $past(trim_offset_in));
  endproperty
  a_trim: assert property (p_trim)
    else $error("trim not applied to result");

  property p_ovr_rsvd;
    @(posedge sys_clk_in) disable iff (!nrst_in)
    ar_take && (ridx == IDX_OVR) |=> axil_out.rdata[22:14] == 9'h000;
  endproperty
  a_ovr_rsvd: assert property (p_ovr_rsvd)
    else $error("override reserved bits not zero");

endmodule : self_test_control

//--- hw/self_test_pkg.sv
// self-test control package: register map, field positions, codes and carrier types
// assumes a 32-bit AXI4-Lite bus and an external calibration engine and ADC datapath
package self_test_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned ADC_W = 14;
  localparam int unsigned CHAN_W = 4;
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned ECC_W = 4;

  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_CTRL = 10'h020;
  localparam logic [9:0] IDX_OVR = 10'h022;
  localparam logic [9:0] IDX_IRQ_STAT = 10'h030;
  localparam logic [9:0] IDX_IRQ_CLR = 10'h031;
  localparam logic [9:0] IDX_IRQ_EN = 10'h032;
  localparam logic [9:0] IDX_ECC_RSLT = 10'h033;
  localparam logic [9:0] IDX_FAULT = 10'h061;

  // self_test_control fields
  localparam int unsigned CTRL_ECC_LSB = 5;
  localparam int unsigned CTRL_FULL_BIT = 4;
  localparam int unsigned CTRL_PART_BIT = 3;
  localparam int unsigned CTRL_DIG_BIT = 2;
  localparam int unsigned CTRL_ANA_BIT = 1;
  localparam int unsigned CTRL_PASS_BIT = 0;
  // adc_output_override and fault fields
  localparam int unsigned OVR_EN_BIT = 23;
  localparam int unsigned FAULT_CAL_ERR_BIT = 4;

  // fault-injection selector codes; 5..7 reserved
  localparam logic [2:0] ECC_NONE = 3'h0;
  localparam logic [2:0] ECC_USER_CORR = 3'h1;
  localparam logic [2:0] ECC_USER_UNCORR = 3'h2;
  localparam logic [2:0] ECC_VEND_CORR = 3'h3;
  localparam logic [2:0] ECC_VEND_UNCORR = 3'h4;

  // interrupt status bits
  localparam int unsigned IRQ_FULL_DONE = 0;
  localparam int unsigned IRQ_PART_DONE = 1;
  localparam int unsigned IRQ_CAL_FAIL = 2;
  localparam int unsigned IRQ_PART_IGNORED = 3;

  localparam logic [13:0] ADC_MAX = 14'h1FFF;
  localparam logic [13:0] ADC_MIN = 14'h2000;
  localparam logic [13:0] OVR_VAL_RESET = 14'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_PARTIAL = 2'b10,
    CAL_FULL = 2'b01
  } cal_state_t;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

  typedef struct packed {
    logic valid;
    logic [CHAN_W-1:0] chan;
    logic [ADC_W-1:0] data;
  } adc_sample_t;

  typedef struct packed {
    logic aw_have;
    logic [ADDR_W-1:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    cal_state_t cal_state;
    logic cal_start;
    logic cal_abort;
    logic cal_err;
    logic [2:0] ecc_sel;
    logic [ECC_W-1:0] ecc_result;
    logic [2:0] trips;
    logic ovr_en;
    logic [ADC_W-1:0] ovr_val;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_enable;
    adc_sample_t result;
  } state_t;

endpackage : self_test_pkg

//--- verification/cal_engine_model.sv
// calibration engine stand-in: answers a start with one done pulse
// assumes start/abort pulses from the self-test block on the same clock
`timescale 1ns/10ps
module cal_engine_model (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // from the block
  input wire logic cal_start_in,
  input wire logic cal_abort_in,
  // scenario controls
  input wire logic slow_in,
  input wire logic fail_in,
  // to the block
  output logic cal_done_out,
  output logic cal_fail_out
);
  logic [7:0] cnt_q;
  logic run_q;
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q <= 8'h00;
      run_q <= 1'b0;
      cal_done_out <= 1'b0;
      cal_fail_out <= 1'b0;
    end else begin
      cal_done_out <= 1'b0;
      // fail only means something beside done, so it toggles otherwise
      cal_fail_out <= ~cal_fail_out;
      if (cal_start_in) begin
        run_q <= 1'b1;
        cnt_q <= slow_in ? 8'h78 : 8'h04;
      end else if (cal_abort_in) begin
        run_q <= 1'b0;
      end else if (run_q && cnt_q == 8'h00) begin
        // compare result only; stored factory values are never written
        run_q <= 1'b0;
        cal_done_out <= 1'b1;
        cal_fail_out <= fail_in;
      end else if (run_q) begin
        cnt_q <= cnt_q - 8'h01;
      end
    end
  end
endmodule : cal_engine_model

//--- verification/tb_battery_monitor_self_test_control.sv
// self-checking bench for the self-test control block
// assumes the block alone on one 20 MHz clock, engine model on the far side
`timescale 1ns/10ps
`define CHK(a, b) chk_v(34'(a), 34'(b))
module tb_battery_monitor_self_test_control
  import self_test_pkg::*;
;
  localparam logic [11:0] A_CTRL = {IDX_CTRL, 2'b00};
  localparam logic [11:0] A_OVR = {IDX_OVR, 2'b00};
  localparam logic [11:0] A_STAT = {IDX_IRQ_STAT, 2'b00};
  localparam logic [11:0] A_CLR = {IDX_IRQ_CLR, 2'b00};
  localparam logic [11:0] A_EN = {IDX_IRQ_EN, 2'b00};
  localparam logic [11:0] A_ECC = {IDX_ECC_RSLT, 2'b00};
  localparam logic [11:0] A_FLT = {IDX_FAULT, 2'b00};
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  axil_req_t req = '0;
  axil_rsp_t rsp;
  adc_sample_t smp = '0;
  adc_sample_t res;
  logic [13:0] trim = 14'h0000;
  logic cal_start, cal_full, cal_abort, cal_busy, cal_done, cal_fail;
  logic [3:0] ecc;
  logic dig, ana, pas, irq;
  logic slow = 1'b0;
  logic fail_mode = 1'b0;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  integer seed = 32'h6DC6B190;
  logic [33:0] rq[$];
  logic [17:0] aq[$];
  logic [3:0] acc;
  logic [13:0] v, t, r;
  logic [2:0] codes[8] = '{3'h0, 3'h5, 3'h6, 3'h7, 3'h1, 3'h2, 3'h3, 3'h4};

  always #25 sys_clk_in = ~sys_clk_in;

  self_test_control u_dut (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .axil_in(req), .axil_out(rsp),
    .cal_start_out(cal_start), .cal_full_out(cal_full), .cal_abort_out(cal_abort),
    .cal_busy_out(cal_busy), .cal_done_in(cal_done), .cal_fail_in(cal_fail),
    .error_check_result_out(ecc), .digital_die_overtemp_force_out(dig),
    .analog_die_overtemp_force_out(ana), .pass_transistor_check_force_out(pas),
    .adc_sample_in(smp), .trim_offset_in(trim), .adc_result_out(res), .irq_out(irq)
  );

  cal_engine_model u_eng (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .cal_start_in(cal_start),
    .cal_abort_in(cal_abort), .slow_in(slow), .fail_in(fail_mode),
    .cal_done_out(cal_done), .cal_fail_out(cal_fail)
  );

  task chk_v(input logic [33:0] a, input logic [33:0] b);
    n_compared++;
    if (a !== b) begin
      mismatches++;
      $display("unexpected t=%0t got=%h exp=%h", $time, a, b);
    end
  endtask : chk_v

  task wrap_up;
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'b0;
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    while (!done) begin
      @(posedge sys_clk_in);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1) begin
        `CHK(rsp.bresp, er);
        req.bready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge sys_clk_in);
  endtask : wr

  task rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    rq.push_back({er, d});
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1);
    req.rready <= 1'b0;
    @(posedge sys_clk_in);
  endtask : rd

  function automatic logic [13:0] sat(input logic [13:0] a, input logic [13:0] b);
    logic signed [14:0] s;
    s = $signed({a[13], a}) + $signed({b[13], b});
    if (s > 15'sd8191) return 14'h1FFF;
    if (s < -15'sd8192) return 14'h2000;
    return s[13:0];
  endfunction : sat

  task adc(input logic [13:0] raw, input logic [13:0] tr, input logic [13:0] ex);
    logic [3:0] ch;
    ch = 4'($random(seed));
    aq.push_back({ch, ex});
    smp <= '{valid: 1'b1, chan: ch, data: raw};
    trim <= tr;
    @(posedge sys_clk_in);
    smp.valid <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
  endtask : adc

  task wait_idle;
    repeat (300) begin
      @(posedge sys_clk_in);
      if (cal_busy === 1'b0) break;
    end
  endtask : wait_idle

  always @(posedge sys_clk_in) begin
    if (rsp.rvalid === 1'b1 && req.rready && rq.size() > 0) begin
      `CHK({rsp.rresp, rsp.rdata}, rq.pop_front());
    end
    if (res.valid === 1'b1) begin
      `CHK({res.chan, res.data}, aq.size() > 0 ? aq.pop_front() : 18'h3FFFF);
    end
    cycles++;
    // generous: the whole sequence needs well under 3000 cycles
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end

  initial begin
    repeat (10) @(posedge sys_clk_in);
    nrst_in <= 1'b1;
    @(posedge sys_clk_in);
    rd(A_CTRL, 32'h0, RESP_OKAY);
    rd(A_OVR, 32'h0, RESP_OKAY);
    wr(A_CTRL, 32'h0000FC00, RESP_OKAY);
    rd(A_CTRL, 32'h0, RESP_OKAY);
    wr(A_OVR, 32'h007FC000, RESP_OKAY);
    rd(A_OVR, 32'h0, RESP_OKAY);
    wr(12'hFF0, 32'h1, RESP_SLVERR);
    rd(12'hFF0, 32'h0, RESP_SLVERR);
    rd(A_CLR, 32'h0, RESP_OKAY);
    acc = 4'h0;
    foreach (codes[i]) begin
      wr(A_CTRL, 32'(codes[i]) << CTRL_ECC_LSB, RESP_OKAY);
      if (codes[i] inside {[3'h1:3'h4]}) acc[codes[i] - 3'h1] = 1'b1;
      rd(A_ECC, 32'(acc), RESP_OKAY);
      `CHK(ecc, acc);
    end
    // full check that fails, with a partial request thrown in
    wr(A_EN, 32'hF, RESP_OKAY);
    fail_mode <= 1'b1;
    slow <= 1'b1;
    wr(A_CTRL, 32'h10, RESP_OKAY);
    rd(A_CTRL, 32'h10, RESP_OKAY);
    wr(A_CTRL, 32'h08, RESP_OKAY);
    rd(A_CTRL, 32'h10, RESP_OKAY);
    `CHK(cal_full, 1'b1);
    wait_idle(); // one test at a time
    rd(A_CTRL, 32'h0, RESP_OKAY);
    rd(A_FLT, 32'h10, RESP_OKAY);
    rd(A_STAT, 32'hD, RESP_OKAY);
    `CHK(irq, 1'b1);
    wr(A_CLR, 32'hF, RESP_OKAY);
    `CHK(irq, 1'b0);
    // partial aborted by a full start that passes
    fail_mode <= 1'b0;
    wr(A_EN, 32'h0, RESP_OKAY);
    wr(A_CTRL, 32'h08, RESP_OKAY);
    rd(A_CTRL, 32'h08, RESP_OKAY);
    `CHK(cal_busy, 1'b1);
    `CHK(cal_full, 1'b0);
    wr(A_CTRL, 32'h10, RESP_OKAY);
    rd(A_CTRL, 32'h10, RESP_OKAY);
    wait_idle();
    rd(A_FLT, 32'h0, RESP_OKAY);
    // lone partial with its interrupt masked, then unmasked
    slow <= 1'b0;
    wr(A_CLR, 32'hF, RESP_OKAY);
    wr(A_CTRL, 32'h08, RESP_OKAY);
    wait_idle();
    rd(A_CTRL, 32'h0, RESP_OKAY);
    rd(A_STAT, 32'h2, RESP_OKAY);
    `CHK(irq, 1'b0);
    wr(A_EN, 32'h2, RESP_OKAY);
    `CHK(irq, 1'b1);
    wr(A_CLR, 32'h2, RESP_OKAY);
    `CHK(irq, 1'b0);
    // each forced trip, then the reset it causes
    for (int i = 0; i < 3; i++) begin
      wr(A_CTRL, 32'(1) << i, RESP_OKAY);
      `CHK({dig, ana, pas}, 3'(1) << i);
      nrst_in <= 1'b0;
      @(posedge sys_clk_in);
      nrst_in <= 1'b1;
      @(posedge sys_clk_in);
      `CHK({dig, ana, pas}, 3'h0);
    end
    // override at both ends of the range, random, then disabled
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? ADC_MAX : (i == 1) ? ADC_MIN : 14'($random(seed));
      // zero trim on one pass so the plain substitution check is exercised
      t = (i == 0) ? 14'h0005 : (i == 1) ? 14'h3FFB : (i == 2) ? 14'h0000 : 14'($random(seed));
      r = 14'($random(seed));
      wr(A_OVR, {8'h00, i < 5, 9'h000, v}, RESP_OKAY);
      rd(A_OVR, {8'h00, i < 5, 9'h000, v}, RESP_OKAY);
      adc(r, t, (i < 5) ? sat(v, t) : sat(r, t));
    end
    repeat (3) @(posedge sys_clk_in);
    wrap_up();
  end
endmodule : tb_battery_monitor_self_test_control
